// ### ext_int_ctrl_pkg.sv
/*
 * constants shared by the external pin interrupt unit: register map,
 * field layout, sense encodings and reset values.
 * assumes a 32-bit plain register port with byte addresses.
 */
`default_nettype none
package ext_int_ctrl_pkg;
    localparam int LINES = 18;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] NMI_CFG_OFS = 8'h04;
    localparam logic [7:0] EVENT_OUTPUT_CONTROL_OFS = 8'h08;
    localparam logic [7:0] INTERRUPT_ENABLE_SETTER_OFS = 8'h0C;
    localparam logic [7:0] INTENCLR_OFS = 8'h10;
    localparam logic [7:0] FLAG_OFS = 8'h14;
    localparam logic [7:0] NMI_FLAG_OFS = 8'h18;
    localparam logic [7:0] PROTECT_OFS = 8'h1C;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
    localparam logic [7:0] CONFIG0_OFS = 8'h30;
    localparam logic [7:0] CONFIG_LAST_OFS = 8'h38;
    localparam int CTRL_SOFT_RESET_BIT_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CFG_FIELD_W = 4;
    localparam int CFG_PER_REG = 8;
    localparam int FILTEN_BIT = 3;
    localparam int EV_FLAG_BIT = 0;
    localparam int EV_NMI_BIT = 1;
    localparam logic [31:0] ZERO_32 = 32'h0000_0000;
    localparam logic [2:0] SENSE_NONE = 3'h0;
    localparam logic [2:0] SENSE_RISE = 3'h1;
    localparam logic [2:0] SENSE_FALL = 3'h2;
    localparam logic [2:0] SENSE_BOTH = 3'h3;
    localparam logic [2:0] SENSE_HIGH = 3'h4;
    localparam logic [2:0] SENSE_LOW = 3'h5;
endpackage
`default_nettype wire

// ### majority_filter.sv
/*
 * three-sample majority vote filter with its input synchroniser.
 * assumes the sample enable is a one-cycle pulse on sys_clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
module majority_filter (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic pin_in,
    input wire logic sample_en_in,
    output logic sync_out,
    output logic filt_out
);
    logic meta_r;
    logic sync_r;
    logic [2:0] samp_r;
    logic [2:0] samp_nxt;
    logic filt_r;
    logic filt_nxt;

    always_comb begin
        samp_nxt = samp_r;
        filt_nxt = filt_r;
        if (sample_en_in) begin
            samp_nxt = {samp_r[1:0], sync_r};
            filt_nxt = (samp_nxt[0] & samp_nxt[1]) |
                       (samp_nxt[1] & samp_nxt[2]) |
                       (samp_nxt[0] & samp_nxt[2]);
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            samp_r <= 3'h0;
            filt_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            samp_r <= samp_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign sync_out = sync_r;
    assign filt_out = filt_r;

    property p_majority;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        sample_en_in |=> filt_r == ((samp_r[0] & samp_r[1]) |
            (samp_r[1] & samp_r[2]) | (samp_r[0] & samp_r[2]));
    endproperty
    a_majority: assert property (p_majority)
        else $error("majority filter output wrong");
endmodule
`default_nettype wire

// ### line_detector.sv
/*
 * sense logic for one external line: edge or level match.
 * assumes the line input is already synchronised.
 */
`timescale 1ns/10ps
`default_nettype none
module line_detector
    import ext_int_ctrl_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic line_in,
    input wire logic [2:0] sense_in,
    input wire logic enable_in,
    output logic hit_out
);
    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = line_in;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    always_comb begin
        hit_out = 1'b0;
        if (enable_in) begin
            case (sense_in)
                SENSE_RISE: hit_out = line_in & ~prev_r;
                SENSE_FALL: hit_out = ~line_in & prev_r;
                SENSE_BOTH: hit_out = line_in ^ prev_r;
                SENSE_HIGH: hit_out = line_in;
                SENSE_LOW: hit_out = ~line_in;
                default: hit_out = 1'b0;
            endcase
        end
    end

    property p_rise;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (enable_in && sense_in == SENSE_RISE && hit_out)
            |-> line_in && !prev_r;
    endproperty
    a_rise: assert property (p_rise)
        else $error("rise hit without edge");
    property p_level;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (enable_in && sense_in == SENSE_HIGH && line_in) |-> hit_out;
    endproperty
    a_level: assert property (p_level)
        else $error("high level not detected");
endmodule
`default_nettype wire

// ### ext_int_ctrl.sv
/*
 * external pin interrupt unit: per-line sense, optional majority
 * filter, flags, enables, event outputs, non-maskable line and
 * a plain register port.
 * assumes pins are asynchronous; registers reached by one-cycle strobes
 * with read data in the following cycle.
 */
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ext_int_ctrl
    import ext_int_ctrl_pkg::*;
#(
    parameter int N = LINES,
    parameter int FILT_DIV = 4
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [N-1:0] ext_int_pin_in,
    input wire logic nmi_pin_in,
    input wire logic debug_halt_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic [N-1:0] line_req_out,
    output logic ext_irq_out,
    output logic nmi_irq_out,
    output logic [N-1:0] event_out,
    output logic irq_out
);
    localparam int NCFG = (N + CFG_PER_REG - 1) / CFG_PER_REG;

    logic enable_r, enable_nxt;
    logic protect_r, protect_nxt;
    logic [N-1:0] inten_r, inten_nxt;
    logic [N-1:0] flag_r, flag_nxt;
    logic [N-1:0] event_output_control_r, event_output_control_nxt;
    logic [CFG_FIELD_W*NCFG*CFG_PER_REG-1:0] cfg_r, cfg_nxt;
    logic [3:0] nmi_cfg_r, nmi_cfg_nxt;
    logic nmi_flag_r, nmi_flag_nxt;
    logic [1:0] stat_r, stat_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [N-1:0] ev_r, ev_nxt;
    logic [7:0] div_r, div_nxt;
    logic tick;
    logic [N:0] hit;
    logic [N:0] sync_w;
    logic [N:0] filt_w;
    logic [N:0] pins_w;
    logic [N:0] path_w;
    logic soft_rst;
    logic wr_ok;
    logic [N-1:0] flag_clr;

    assign pins_w = {nmi_pin_in, ext_int_pin_in};

    // filter sample tick; runs regardless of debug halt
    always_comb begin
        div_nxt = div_r + 8'h01;
        tick = 1'b0;
        if (div_r == 8'(FILT_DIV - 1)) begin
            div_nxt = 8'h00;
            tick = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g <= N; g++) begin : g_line
            logic [2:0] sense;
            logic filt_en;
            if (g < N) begin : g_ext
                assign sense = cfg_r[g*CFG_FIELD_W +: 3];
                assign filt_en = cfg_r[g*CFG_FIELD_W + FILTEN_BIT];
            end else begin : g_nmi
                assign sense = nmi_cfg_r[2:0];
                assign filt_en = nmi_cfg_r[FILTEN_BIT];
            end
            majority_filter u_filt (
                .sys_clk_in(sys_clk_in),
                .resetn_in(resetn_in),
                .pin_in(pins_w[g]),
                .sample_en_in(tick),
                .sync_out(sync_w[g]),
                .filt_out(filt_w[g])
            );
            // filter only in the path when selected
            assign path_w[g] = filt_en ? filt_w[g] : sync_w[g];
            line_detector u_det (
                .sys_clk_in(sys_clk_in),
                .resetn_in(resetn_in),
                .line_in(path_w[g]),
                .sense_in(sense),
                .enable_in(enable_r),
                .hit_out(hit[g])
            );
        end
    endgenerate

    assign soft_rst = wr_in && addr_in == CTRL_OFS &&
                      wdata_in[CTRL_SOFT_RESET_BIT_BIT];
    assign wr_ok = wr_in && !protect_r;
    assign flag_clr = (wr_in && addr_in == FLAG_OFS) ?
                      wdata_in[N-1:0] : '0;

    always_comb begin
        enable_nxt = enable_r;
        protect_nxt = protect_r;
        inten_nxt = inten_r;
        event_output_control_nxt = event_output_control_r;
        cfg_nxt = cfg_r;
        nmi_cfg_nxt = nmi_cfg_r;
        mask_nxt = mask_r;
        rdata_nxt = ZERO_32;
        if (wr_in && addr_in == CTRL_OFS) begin
            enable_nxt = wdata_in[CTRL_ENABLE_BIT];
        end
        if (wr_in && addr_in == PROTECT_OFS) begin
            protect_nxt = wdata_in[0];
        end
        if (wr_ok) begin
            case (addr_in)
                INTERRUPT_ENABLE_SETTER_OFS: inten_nxt = inten_r | wdata_in[N-1:0];
                INTENCLR_OFS: inten_nxt = inten_r & ~wdata_in[N-1:0];
                EVENT_OUTPUT_CONTROL_OFS: event_output_control_nxt = wdata_in[N-1:0];
                NMI_CFG_OFS: nmi_cfg_nxt = wdata_in[3:0];
                IRQ_MASK_OFS: mask_nxt = wdata_in[1:0];
                default: begin
                    for (int i = 0; i < NCFG; i++) begin
                        if (addr_in == CONFIG0_OFS + 8'(4 * i)) begin
                            cfg_nxt[i*32 +: 32] = wdata_in;
                        end
                    end
                end
            endcase
        end
        if (rd_in) begin
            case (addr_in)
                CTRL_OFS: rdata_nxt[CTRL_ENABLE_BIT] = enable_r;
                NMI_CFG_OFS: rdata_nxt[3:0] = nmi_cfg_r;
                EVENT_OUTPUT_CONTROL_OFS: rdata_nxt[N-1:0] = event_output_control_r;
                INTERRUPT_ENABLE_SETTER_OFS: rdata_nxt[N-1:0] = inten_r;
                INTENCLR_OFS: rdata_nxt[N-1:0] = inten_r;
                FLAG_OFS: rdata_nxt[N-1:0] = flag_r;
                NMI_FLAG_OFS: rdata_nxt[0] = nmi_flag_r;
                PROTECT_OFS: rdata_nxt[0] = protect_r;
                IRQ_STAT_OFS: rdata_nxt[1:0] = stat_r;
                IRQ_MASK_OFS: rdata_nxt[1:0] = mask_r;
                default: begin
                    for (int i = 0; i < NCFG; i++) begin
                        if (addr_in == CONFIG0_OFS + 8'(4 * i)) begin
                            rdata_nxt = cfg_r[i*32 +: 32];
                        end
                    end
                end
            endcase
        end
    end

    // flags: a new hit wins over a clear in the same cycle
    always_comb begin
        flag_nxt = (flag_r & ~flag_clr) | hit[N-1:0];
        nmi_flag_nxt = nmi_flag_r;
        if (wr_in && addr_in == NMI_FLAG_OFS && wdata_in[0]) begin
            nmi_flag_nxt = 1'b0;
        end
        nmi_flag_nxt = nmi_flag_nxt | hit[N];
        ev_nxt = hit[N-1:0] & event_output_control_r;
        stat_nxt = stat_r;
        if (rd_in && addr_in == IRQ_STAT_OFS) begin
            stat_nxt = 2'h0;
        end
        stat_nxt[EV_FLAG_BIT] = stat_nxt[EV_FLAG_BIT] | (|hit[N-1:0]);
        stat_nxt[EV_NMI_BIT] = stat_nxt[EV_NMI_BIT] | hit[N];
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            enable_r <= 1'b0;
            protect_r <= 1'b0;
            inten_r <= '0;
            flag_r <= '0;
            event_output_control_r <= '0;
            cfg_r <= '0;
            nmi_cfg_r <= 4'h0;
            nmi_flag_r <= 1'b0;
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            rdata_r <= ZERO_32;
            ev_r <= '0;
            div_r <= 8'h00;
        end else if (soft_rst) begin
            enable_r <= 1'b0;
            protect_r <= 1'b0;
            inten_r <= '0;
            flag_r <= '0;
            event_output_control_r <= '0;
            cfg_r <= '0;
            nmi_cfg_r <= 4'h0;
            nmi_flag_r <= 1'b0;
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            rdata_r <= ZERO_32;
            ev_r <= '0;
            div_r <= 8'h00;
        end else begin
            enable_r <= enable_nxt;
            protect_r <= protect_nxt;
            inten_r <= inten_nxt;
            flag_r <= flag_nxt;
            event_output_control_r <= event_output_control_nxt;
            cfg_r <= cfg_nxt;
            nmi_cfg_r <= nmi_cfg_nxt;
            nmi_flag_r <= nmi_flag_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            ev_r <= ev_nxt;
            div_r <= div_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign line_req_out = flag_r & inten_r;
    assign ext_irq_out = |(flag_r & inten_r);
    assign nmi_irq_out = nmi_flag_r;
    assign event_out = ev_r;
    assign irq_out = |(stat_r & mask_r);

    property p_flag_set;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (hit[0] && !soft_rst) |=> flag_r[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set after detection");
    property p_flag_clr;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (flag_clr[0] && !hit[0]) |=> !flag_r[0];
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("flag not cleared by write of one");
    property p_enable;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (wr_in && addr_in == CTRL_OFS && !wdata_in[CTRL_SOFT_RESET_BIT_BIT])
            |=> enable_r == $past(wdata_in[CTRL_ENABLE_BIT]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable bit not taken");
    property p_soft_reset_bit;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        soft_rst |=> !enable_r && inten_r == '0 && flag_r == '0;
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit)
        else $error("soft reset left state behind");
    property p_inten;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (!wr_in || addr_in != INTENCLR_OFS) && !soft_rst
            |=> (inten_r & $past(inten_r)) == $past(inten_r);
    endproperty
    a_inten: assert property (p_inten)
        else $error("enable bit lost without clear");
    property p_protect;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (protect_r && flag_clr[7] && !hit[7] && !soft_rst) |=> !flag_r[7];
    endproperty
    a_protect: assert property (p_protect)
        else $error("flag clear blocked by protection");
    property p_req;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (flag_r[0] && inten_r[0]) |-> line_req_out[0] && ext_irq_out;
    endproperty
    a_req: assert property (p_req)
        else $error("request not tied to flag and enable");
    property p_event;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (hit[0] && event_output_control_r[0] && !soft_rst) |=> event_out[0];
    endproperty
    a_event: assert property (p_event)
        else $error("event not generated");
    // detection keeps working while the processor is halted
    property p_halt;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        (debug_halt_in && hit[N] && !soft_rst) |=> nmi_flag_r;
    endproperty
    a_halt: assert property (p_halt)
        else $error("nmi flag not set during halt");
endmodule
`default_nettype wire

// ### ext_pin_model.sv
/*
 * model of the outside circuitry on the external interrupt pins.
 * assumes the bench sets the wanted levels; pins move off the clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ext_pin_model #(
    parameter int N = 18
) (
    input wire logic [N-1:0] level_in,
    input wire logic nmi_level_in,
    output logic [N-1:0] pin_out,
    output logic nmi_out
);
    // pins move 3 ns after the bench, away from any sampling edge
    assign #3 pin_out = level_in;
    assign #3 nmi_out = nmi_level_in;
endmodule
`default_nettype wire

// ### testbench.sv
/*
 * testbench for the external pin interrupt unit: register tasks,
 * sense modes, filter, nmi, irq, protection, disable, soft reset.
 * assumes the register map and sense codes of the package.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ext_int_ctrl_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [LINES-1:0] lvl = '0;
    logic nmi_lvl = 1'b0;
    logic halt = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = ZERO_32;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [LINES-1:0] pins;
    logic nmi_pin;
    logic [31:0] rdata;
    logic [LINES-1:0] line_req;
    logic [LINES-1:0] ev;
    logic ext_irq;
    logic nmi_irq;
    logic irq;
    logic [31:0] d;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int ev0 = 0;
    int ev_rest = 0;

    ext_pin_model #(.N(LINES)) pin_model (.level_in(lvl),
        .nmi_level_in(nmi_lvl), .pin_out(pins), .nmi_out(nmi_pin));
    ext_int_ctrl #(.N(LINES), .FILT_DIV(4)) dut (.sys_clk_in(sys_clk),
        .resetn_in(resetn), .ext_int_pin_in(pins), .nmi_pin_in(nmi_pin),
        .debug_halt_in(halt), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .line_req_out(line_req), .ext_irq_out(ext_irq),
        .nmi_irq_out(nmi_irq), .event_out(ev), .irq_out(irq));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end

    // event pulses counted mid-cycle, where they are settled
    always @(negedge sys_clk) begin
        if (ev[0] === 1'b1) begin
            ev0++;
        end
        if (|ev[LINES-1:1] !== 1'b0) begin
            ev_rest++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_reg(input string name, input logic [7:0] a,
        input logic [31:0] exp);
        logic [31:0] v;
        rd_reg(a, v);
        check(name, v, exp);
    endtask

    task automatic set_pins(input logic [LINES-1:0] v, input int n);
        @(posedge sys_clk);
        lvl <= v;
        tick(n);
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        chk_reg("ctrl_reset", CTRL_OFS, ZERO_32);
        chk_reg("interrupt_enable_setter_reset", INTERRUPT_ENABLE_SETTER_OFS, ZERO_32);
        // configuration first, enable last
        wr_reg(CONFIG0_OFS, 32'h1905_4321);
        wr_reg(EVENT_OUTPUT_CONTROL_OFS, 32'h0000_0001);
        wr_reg(NMI_CFG_OFS, 32'h0000_0001);
        wr_reg(INTERRUPT_ENABLE_SETTER_OFS, 32'h0000_003F);
        wr_reg(INTERRUPT_ENABLE_SETTER_OFS, ZERO_32);
        wr_reg(CTRL_OFS, 32'h0000_0002);
        chk_reg("interrupt_enable_setter", INTERRUPT_ENABLE_SETTER_OFS, 32'h0000_003F);
        chk_reg("unmapped", 8'h2C, ZERO_32);
        tick(6);
        chk_reg("flag_low", FLAG_OFS, 32'h0000_0010);
        $display("test bring_up done");

        ev0 = 0;
        ev_rest = 0;
        set_pins(18'h0001F, 6);
        chk_reg("flag_rise", FLAG_OFS, 32'h0000_001D);
        check("line_req", 32'(line_req), 32'h0000_001D);
        check("ext_irq", 32'(ext_irq), 32'h0000_0001);
        check("event0", 32'(ev0), 32'h0000_0001);
        check("event_rest", 32'(ev_rest), ZERO_32);
        wr_reg(FLAG_OFS, 32'h0000_003F);
        tick(2);
        chk_reg("flag_relevel", FLAG_OFS, 32'h0000_0008);
        set_pins('0, 6);
        chk_reg("flag_fall", FLAG_OFS, 32'h0000_001E);
        $display("test sense_modes done");

        wr_reg(FLAG_OFS, 32'h0003_FFFF);
        set_pins(18'h000C0, 2);
        set_pins('0, 12);
        chk_reg("filt_glitch", FLAG_OFS, 32'h0000_0090);
        set_pins(18'h00040, 20);
        chk_reg("filt_hold", FLAG_OFS, 32'h0000_00D0);
        check("req_off", 32'(line_req[7]), ZERO_32);
        set_pins('0, 1);
        $display("test filter done");

        @(posedge sys_clk);
        halt <= 1'b1;
        wr_reg(PROTECT_OFS, 32'h0000_0001);
        wr_reg(INTENCLR_OFS, 32'h0000_003F);
        chk_reg("prot_enable", INTERRUPT_ENABLE_SETTER_OFS, 32'h0000_003F);
        wr_reg(FLAG_OFS, 32'h0003_FFFF);
        chk_reg("prot_flag", FLAG_OFS, 32'h0000_0010);
        @(posedge sys_clk);
        nmi_lvl <= 1'b1;
        tick(6);
        check("irq_masked", 32'(irq), ZERO_32);
        check("nmi_irq", 32'(nmi_irq), 32'h0000_0001);
        chk_reg("nmi_flag", NMI_FLAG_OFS, 32'h0000_0001);
        wr_reg(NMI_FLAG_OFS, 32'h0000_0001);
        tick(1);
        check("nmi_clear", 32'(nmi_irq), ZERO_32);
        wr_reg(PROTECT_OFS, ZERO_32);
        wr_reg(IRQ_MASK_OFS, 32'h0000_0002);
        tick(1);
        check("irq_raised", 32'(irq), 32'h0000_0001);
        rd_reg(IRQ_STAT_OFS, d);
        check("irq_stat", d & 32'h0000_0002, 32'h0000_0002);
        tick(1);
        check("irq_cleared", 32'(irq), ZERO_32);
        @(posedge sys_clk);
        halt <= 1'b0;
        $display("test nmi_irq_protect done");

        wr_reg(CTRL_OFS, ZERO_32);
        wr_reg(FLAG_OFS, 32'h0003_FFFF);
        set_pins(18'h00001, 6);
        chk_reg("flag_disabled", FLAG_OFS, ZERO_32);
        wr_reg(CTRL_OFS, 32'h0000_0002);
        wr_reg(CTRL_OFS, 32'h0000_0003);
        chk_reg("soft_reset_bit_ctrl", CTRL_OFS, ZERO_32);
        chk_reg("soft_reset_bit_enable", INTERRUPT_ENABLE_SETTER_OFS, ZERO_32);
        chk_reg("soft_reset_bit_config", CONFIG0_OFS, ZERO_32);
        chk_reg("soft_reset_bit_event", EVENT_OUTPUT_CONTROL_OFS, ZERO_32);
        chk_reg("soft_reset_bit_flag", FLAG_OFS, ZERO_32);
        $display("test disable_reset done");
        close_out();
    end
endmodule
`default_nettype wire
